// *** inc/bbs_alu_if.sv ***
// carrier between the datapath top and its BCD adder
// one clockless bundle; both ends in the same clock domain
`timescale 1ns/1ps
`include "bbs_params.svh"
interface bbs_alu_if;
    logic [`BBS_DATA_W-1:0] augend;
    logic [`BBS_DATA_W-1:0] addend;
    logic subtract;
    logic [`BBS_DATA_W-1:0] result;
    logic carry16;
    logic carry32;
    logic invalidBcd;

    modport user (
        output augend,
        output addend,
        output subtract,
        input result,
        input carry16,
        input carry32,
        input invalidBcd
    );

    modport alu (
        input augend,
        input addend,
        input subtract,
        output result,
        output carry16,
        output carry32,
        output invalidBcd
    );
endinterface

// *** inc/bbs_params.svh ***
// constants of the formatted BCD add/sub and word decrement datapath
// included by the package, the interface and the design modules
`ifndef BBS_PARAMS_SVH
`define BBS_PARAMS_SVH

// ==========================================
// widths and sizes
`define BBS_DATA_W 32
`define BBS_WORD_W 16
`define BBS_WORD_N 16
`define BBS_BIT_N 256
`define BBS_BITW_N 8
`define BBS_DIGIT_N 8
`define BBS_FLAG_W 7

// ==========================================
// instruction operand limits
`define BBS_CNT_MIN 6'h01
`define BBS_CNT_MAX 6'h20
`define BBS_WORD_LIMIT 8'h10
`define BBS_DEC_STEP 16'h0001

// ==========================================
// register offsets (byte addresses)
`define BBS_OFS_ACC 8'h00
`define BBS_OFS_FLAG 8'h04
`define BBS_OFS_STAT 8'h08
`define BBS_OFS_RESULT 8'h0C
`define BBS_OFS_OPERAND 8'h10
`define BBS_BIT_SEL 3'h2
`define BBS_WORD_SEL 2'h2

// ==========================================
// reset values
`define BBS_ACC_RST 32'h00000000
`define BBS_FLAG_RST 7'h00

`endif

// *** inc/bbs_pkg.sv ***
// types of the formatted BCD add/sub and word decrement datapath
// needs nothing but the constants header
`include "bbs_params.svh"
package bbs_pkg;

    // ==========================================
    // operations issued by the sequencer
    typedef enum logic [1:0] {
        BBS_OP_NONE = 2'h0,
        BBS_OP_WORD_DECREMENT = 2'h1,
        BBS_OP_BITRANGE_BCD_ADD = 2'h2,
        BBS_OP_BITRANGE_BCD_SUB = 2'h3
    } bbs_op_type;

    // ==========================================
    // sequencing states, gray along idle-calc-done
    typedef enum logic [1:0] {
        BBS_ST_IDLE = 2'h0,
        BBS_ST_CALC = 2'h1,
        BBS_ST_DONE = 2'h3
    } bbs_state_type;

    // ==========================================
    // status flags, bit 6 first
    typedef struct packed {
        logic invalidBcdFlag;
        logic negativeFlag;
        logic carry32Flag;
        logic carry16Flag;
        logic borrow32Flag;
        logic borrow16Flag;
        logic zeroResultFlag;
    } bbs_flags_type;

endpackage

// *** tb/bbs_arith_sva.sv ***
// concurrent checks on the word decrement and bit-range BCD datapath
// sees only the top module's ports; bound to every bbs_arith_top instance
`timescale 1ns/1ps
`include "bbs_params.svh"
module bbs_arith_sva (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // instruction port
    input logic instStart,
    input bbs_pkg::bbs_op_type instOp,
    input logic [7:0] instSrcAddr,
    input logic [5:0] instBitCount,
    input logic instBusy,
    input logic instDone,
    input logic instReject,
    // register port
    input logic regWrEn,
    // results
    input logic [`BBS_DATA_W-1:0] accValue,
    input logic zeroResultFlag,
    input logic borrow32Flag,
    input logic carry16Flag,
    input logic negativeFlag
);
    import bbs_pkg::*;
    bbs_op_type opQ;
    logic legalStart, badStart, fmtBusy, addBusy;
    // ==========================================
    // helper decode
    assign legalStart = instStart && !instBusy && ((instOp == BBS_OP_WORD_DECREMENT
        && instSrcAddr < `BBS_WORD_LIMIT) || (instOp[1] && instBitCount >= `BBS_CNT_MIN
        && instBitCount <= `BBS_CNT_MAX));
    assign badStart = instStart && !instBusy && !legalStart;
    assign fmtBusy = instBusy && opQ != BBS_OP_WORD_DECREMENT;
    assign addBusy = instBusy && opQ == BBS_OP_BITRANGE_BCD_ADD;
    // opQ stays valid through the done cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            opQ <= BBS_OP_NONE;
        end else if (legalStart) begin
            opQ <= instOp;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence takeSeq;
        legalStart;
    endsequence
    sequence runSeq;
        instBusy [*2] ##1 !instBusy;
    endsequence
    busy_run_a: assert property (takeSeq |=> runSeq)
        else $error("busy window wrong after accepted start");
    done_after_take_a: assert property (takeSeq |-> ##2 instDone)
        else $error("done not two cycles after start");
    reject_pulse_a: assert property (badStart |=> instReject ##1 !instReject)
        else $error("illegal start not refused with one pulse");
    acc_hold_a: assert property ($changed(accValue) |->
        $past(fmtBusy) || $past(regWrEn) || !$past(rst_n))
        else $error("accumulator changed without cause");
    zero_hold_a: assert property ($changed(zeroResultFlag) |->
        $past(instBusy) || $past(regWrEn) || !$past(rst_n))
        else $error("zero flag changed without cause");
    carry_hold_a: assert property ($changed(carry16Flag) |->
        $past(addBusy) || $past(regWrEn) || !$past(rst_n))
        else $error("carry flag changed outside an add");
    zero_match_a: assert property (instDone && opQ != BBS_OP_WORD_DECREMENT |->
        zeroResultFlag == (accValue == 32'h0))
        else $error("zero flag disagrees with accumulator");
    neg_sub_a: assert property (instDone && opQ == BBS_OP_BITRANGE_BCD_SUB |->
        negativeFlag == borrow32Flag)
        else $error("negative flag disagrees with borrow");
    neg_add_a: assert property (instDone && opQ == BBS_OP_BITRANGE_BCD_ADD |->
        !negativeFlag)
        else $error("negative flag set after add");
endmodule
bind bbs_arith_top bbs_arith_sva u_sva (
    .clk(clk), .rst_n(rst_n), .instStart(instStart), .instOp(instOp),
    .instSrcAddr(instSrcAddr), .instBitCount(instBitCount), .instBusy(instBusy),
    .instDone(instDone), .instReject(instReject), .regWrEn(regWrEn), .accValue(accValue),
    .zeroResultFlag(zeroResultFlag), .borrow32Flag(borrow32Flag),
    .carry16Flag(carry16Flag), .negativeFlag(negativeFlag)
);

// *** tb/bbs_arith_top_test.sv ***
// self-checking bench for the word decrement and bit-range BCD datapath
// drives the sequencer and register ports directly; no partner model
`timescale 1ns/1ps
`include "bbs_params.svh"
module bbs_arith_top_test;
    import bbs_pkg::*;
    typedef struct packed {
        logic [31:0] acc;
        bbs_op_type op;
        logic [7:0] src;
        logic [5:0] cnt;
        logic [31:0] opnd;
    } bbs_case_type;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instStart = 1'b0;
    bbs_op_type instOp = BBS_OP_NONE;
    logic [7:0] instSrcAddr = 8'h00;
    logic [5:0] instBitCount = 6'h00;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic instBusy, instDone, instReject;
    logic [31:0] regRdData, accValue;
    logic zeroResultFlag, borrow16Flag, borrow32Flag, carry16Flag, carry32Flag;
    logic negativeFlag, invalidBcdFlag;
    logic [6:0] flagPort, eFlags;
    bbs_case_type cases [7];
    bbs_case_type rej [4];
    int failCount = 0;
    int testsRun = 0;
    assign flagPort = {invalidBcdFlag, negativeFlag, carry32Flag, carry16Flag,
        borrow32Flag, borrow16Flag, zeroResultFlag};
    always #50 clk = ~clk;
    bbs_arith_top u_dut (
        .clk(clk), .rst_n(rst_n), .instStart(instStart), .instOp(instOp),
        .instSrcAddr(instSrcAddr), .instBitCount(instBitCount), .instBusy(instBusy),
        .instDone(instDone), .instReject(instReject), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .accValue(accValue), .zeroResultFlag(zeroResultFlag),
        .borrow16Flag(borrow16Flag), .borrow32Flag(borrow32Flag),
        .carry16Flag(carry16Flag), .carry32Flag(carry32Flag),
        .negativeFlag(negativeFlag), .invalidBcdFlag(invalidBcdFlag)
    );
    // ==========================================
    // reference arithmetic, digit by digit
    function automatic logic [33:0] bcdCalc(input logic [31:0] a, input logic [31:0] b,
        input logic sub);
        logic [31:0] r;
        logic [4:0] s;
        logic c, c16;
        c = sub;
        c16 = 1'b0;
        r = 32'h0;
        for (int i = 0; i < 8; i++) begin
            s = {1'b0, a[4*i+:4]} + {1'b0, (sub ? 4'h9 - b[4*i+:4] : b[4*i+:4])} + {4'h0, c};
            c = s > 5'h09;
            if (c) begin
                s = s + 5'h06;
            end
            r[4*i+:4] = s[3:0];
            if (i == 3) begin
                c16 = c;
            end
        end
        return {c, c16, r};
    endfunction
    function automatic logic hasBad(input logic [31:0] x);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < 8; i++) begin
            bad |= x[4*i+:4] > 4'h9;
        end
        return bad;
    endfunction
    // ==========================================
    // access tasks
    task automatic giveVerdict;
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic checkFlags(input string what);
        check({25'h0, flagPort}, {25'h0, eFlags}, what);
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask
    // waits at falling edges for done, or reject when a refusal is expected
    task automatic runOp(input bbs_op_type op, input logic [7:0] src, input logic [5:0] cnt,
        input logic expRej);
        logic seen;
        @(posedge clk);
        instOp <= op;
        instSrcAddr <= src;
        instBitCount <= cnt;
        instStart <= 1'b1;
        @(posedge clk);
        instStart <= 1'b0;
        seen = 1'b0;
        for (int n = 0; n < 8 && !seen; n++) begin
            @(negedge clk);
            seen = expRej ? instReject === 1'b1 : instDone === 1'b1;
        end
        if (!seen) begin
            failCount++;
            $display("Error at %0t: no answer to instruction", $time);
            giveVerdict();
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        logic [31:0] d, accOld;
        logic [33:0] r;
        logic inv, sub;
        cases = '{'{32'h00009999, BBS_OP_BITRANGE_BCD_ADD, 8'h04, 6'h08, 32'h00000032},
            '{32'h99999999, BBS_OP_BITRANGE_BCD_ADD, 8'h00, 6'h01, 32'h00000001},
            '{32'h00000010, BBS_OP_BITRANGE_BCD_SUB, 8'h1C, 6'h08, 32'h00000098},
            '{32'h00050000, BBS_OP_BITRANGE_BCD_SUB, 8'h04, 6'h08, 32'h00000032},
            '{32'h00000032, BBS_OP_BITRANGE_BCD_SUB, 8'h04, 6'h08, 32'h00000032},
            '{32'h0000000A, BBS_OP_BITRANGE_BCD_ADD, 8'h00, 6'h01, 32'h00000001},
            '{32'h12345678, BBS_OP_BITRANGE_BCD_ADD, 8'h00, 6'h20, 32'h87654321}};
        rej = '{'{32'h0, BBS_OP_NONE, 8'h00, 6'h01, 32'h0},
            '{32'h0, BBS_OP_WORD_DECREMENT, 8'h10, 6'h00, 32'h0},
            '{32'h0, BBS_OP_BITRANGE_BCD_ADD, 8'h00, 6'h00, 32'h0},
            '{32'h0, BBS_OP_BITRANGE_BCD_SUB, 8'h00, 6'h21, 32'h0}};
        eFlags = 7'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        regRead(`BBS_OFS_ACC, d);
        check(d, 32'h0, "acc after reset");
        regRead(`BBS_OFS_FLAG, d);
        check(d, 32'h0, "flags after reset");
        regRead(8'h30, d);
        check(d, 32'h0, "unmapped read");
        regWrite(8'h40, 32'h87654321);
        regWrite(8'h44, 32'h00000099);
        for (int i = 0; i < 7; i++) begin
            regWrite(`BBS_OFS_ACC, cases[i].acc);
            runOp(cases[i].op, cases[i].src, cases[i].cnt, 1'b0);
            sub = cases[i].op == BBS_OP_BITRANGE_BCD_SUB;
            r = bcdCalc(cases[i].acc, cases[i].opnd, sub);
            inv = hasBad(cases[i].acc) || hasBad(cases[i].opnd);
            eFlags[0] = r[31:0] == 32'h0;
            eFlags[6] = inv;
            if (sub) begin
                eFlags[2:1] = ~r[33:32];
                eFlags[5] = !r[33];
            end else begin
                eFlags[4:3] = r[33:32];
                eFlags[5] = 1'b0;
            end
            // a non-decimal operand leaves the sum undefined
            if (!inv) begin
                check(accValue, r[31:0], "formatted result");
            end
            checkFlags("formatted flags");
            regRead(`BBS_OFS_OPERAND, d);
            check(d, cases[i].opnd, "gathered operand");
        end
        regWrite(8'h8C, 32'h00000001);
        accOld = accValue;
        runOp(BBS_OP_WORD_DECREMENT, 8'h03, 6'h00, 1'b0);
        eFlags[0] = 1'b1;
        regRead(8'h8C, d);
        check(d, 32'h0, "decrement to zero");
        check({25'h0, flagPort}, {25'h0, eFlags}, "decrement zero flags");
        runOp(BBS_OP_WORD_DECREMENT, 8'h03, 6'h00, 1'b0);
        eFlags[0] = 1'b0;
        regRead(8'h8C, d);
        check(d, 32'h0000FFFF, "decrement wrap");
        check({25'h0, flagPort}, {25'h0, eFlags}, "decrement wrap flags");
        check(accValue, accOld, "acc kept by decrement");
        regRead(`BBS_OFS_RESULT, d);
        check(d, 32'h0000FFFF, "last result");
        regRead(`BBS_OFS_STAT, d);
        check(d, 32'h00000008, "status after decrement");
        // read data stand for one cycle only
        @(posedge clk);
        #1 check(regRdData, 32'h0, "read data after its cycle");
        for (int i = 0; i < 4; i++) begin
            accOld = accValue;
            runOp(rej[i].op, rej[i].src, rej[i].cnt, 1'b1);
            check(accValue, accOld, "acc kept by refusal");
            check({25'h0, flagPort}, {25'h0, eFlags}, "flags kept by refusal");
        end
        regWrite(`BBS_OFS_FLAG, 32'h0000007F);
        eFlags = 7'h00;
        #1 check({25'h0, flagPort}, {25'h0, eFlags}, "flags cleared");
        giveVerdict();
    end
endmodule

// *** verilog/bbs_arith_top.sv ***
// datapath for word decrement and bit-range BCD add/subtract
// assumes sequencer and software ports are synchronous to clk
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "bbs_params.svh"
module bbs_arith_top (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // instruction port from the sequencer
    input logic instStart,
    input bbs_pkg::bbs_op_type instOp,
    input logic [7:0] instSrcAddr,
    input logic [5:0] instBitCount,
    output logic instBusy,
    output logic instDone,
    output logic instReject,
    // register port
    input logic [7:0] regAddr,
    input logic [`BBS_DATA_W-1:0] regWrData,
    input logic regWrEn,
    input logic regRdEn,
    output logic [`BBS_DATA_W-1:0] regRdData,
    // accumulator and status bits
    output logic [`BBS_DATA_W-1:0] accValue,
    output logic zeroResultFlag,
    output logic borrow16Flag,
    output logic borrow32Flag,
    output logic carry16Flag,
    output logic carry32Flag,
    output logic negativeFlag,
    output logic invalidBcdFlag
);
    import bbs_pkg::*;

    // ==========================================
    // state
    bbs_state_type stateQ;
    bbs_state_type stateD;
    bbs_op_type opQ;
    logic [7:0] srcQ;
    logic [5:0] cntQ;
    logic rejectQ;
    logic [`BBS_DATA_W-1:0] accQ;
    logic [`BBS_DATA_W-1:0] accD;
    bbs_flags_type flagsQ;
    bbs_flags_type flagsD;
    logic [`BBS_DATA_W-1:0] resultQ;
    logic [`BBS_DATA_W-1:0] operandQ;
    logic [`BBS_DATA_W-1:0] rdDataQ;
    logic [`BBS_DATA_W-1:0] bitMemQ [`BBS_BITW_N];
    logic [`BBS_WORD_W-1:0] wordMemQ [`BBS_WORD_N];

    // ==========================================
    // register decode
    logic selAcc;
    logic selFlag;
    logic selStat;
    logic selResult;
    logic selOperand;
    logic selBit;
    logic selWord;
    logic [2:0] bitIdx;
    logic [3:0] wordIdx;
    logic accWrite;
    logic flagWrite;
    logic bitWrite;
    logic wordWrite;
    logic [`BBS_FLAG_W-1:0] flagClear;
    logic [`BBS_DATA_W-1:0] rdMux;

    assign selAcc = regAddr == `BBS_OFS_ACC;
    assign selFlag = regAddr == `BBS_OFS_FLAG;
    assign selStat = regAddr == `BBS_OFS_STAT;
    assign selResult = regAddr == `BBS_OFS_RESULT;
    assign selOperand = regAddr == `BBS_OFS_OPERAND;
    assign selBit = regAddr[7:5] == `BBS_BIT_SEL;
    assign selWord = regAddr[7:6] == `BBS_WORD_SEL;
    assign bitIdx = regAddr[4:2];
    assign wordIdx = regAddr[5:2];
    assign accWrite = regWrEn && selAcc;
    assign flagWrite = regWrEn && selFlag;
    assign bitWrite = regWrEn && selBit;
    assign wordWrite = regWrEn && selWord;
    assign flagClear = flagWrite ? regWrData[`BBS_FLAG_W-1:0] : `BBS_FLAG_RST;

    // ==========================================
    // instruction acceptance
    logic idle;
    logic isDec;
    logic isFmt;
    logic cntOk;
    logic addrOk;
    logic takeOk;
    logic accept;
    logic refuse;

    assign idle = stateQ == BBS_ST_IDLE;
    assign isDec = instOp == BBS_OP_WORD_DECREMENT;
    assign isFmt = instOp == BBS_OP_BITRANGE_BCD_ADD || instOp == BBS_OP_BITRANGE_BCD_SUB;
    // count outside one to thirty-two is refused, not clamped
    assign cntOk = instBitCount >= `BBS_CNT_MIN && instBitCount <= `BBS_CNT_MAX;
    assign addrOk = instSrcAddr < `BBS_WORD_LIMIT;
    assign takeOk = (isDec && addrOk) || (isFmt && cntOk);
    assign accept = idle && instStart && takeOk;
    assign refuse = idle && instStart && !takeOk;

    // ==========================================
    // operand gathering and BCD arithmetic
    logic [`BBS_BIT_N-1:0] bitVec;
    logic [`BBS_DATA_W-1:0] fmtOperand;
    logic calcNow;
    logic fmtNow;
    logic subNow;
    logic [`BBS_DATA_W-1:0] bcdSum;

    for (genvar w = 0; w < `BBS_BITW_N; w++) begin : g_bitvec
        assign bitVec[`BBS_DATA_W*w +: `BBS_DATA_W] = bitMemQ[w];
    end

    bbs_bit_gather u_gather (
        .bitVec(bitVec),
        .startBit(srcQ),
        .bitCount(cntQ),
        .operand(fmtOperand)
    );

    bbs_alu_if aluBus ();

    bbs_bcd_adder u_adder (
        .alu(aluBus.alu)
    );

    assign calcNow = stateQ == BBS_ST_CALC;
    assign subNow = opQ == BBS_OP_BITRANGE_BCD_SUB;
    assign fmtNow = calcNow && (opQ == BBS_OP_BITRANGE_BCD_ADD || subNow);
    assign aluBus.augend = accQ;
    assign aluBus.addend = fmtOperand;
    assign aluBus.subtract = subNow;
    assign bcdSum = aluBus.result;

    // ==========================================
    // word decrement
    logic decNow;
    logic [3:0] decIdx;
    logic [`BBS_WORD_W-1:0] decNew;

    assign decNow = calcNow && opQ == BBS_OP_WORD_DECREMENT;
    assign decIdx = srcQ[3:0];
    // binary wrap: zero decrements to all ones
    assign decNew = wordMemQ[decIdx] - `BBS_DEC_STEP;

    // ==========================================
    // next state
    always_comb begin
        case (stateQ)
            BBS_ST_IDLE: stateD = accept ? BBS_ST_CALC : BBS_ST_IDLE;
            BBS_ST_CALC: stateD = BBS_ST_DONE;
            BBS_ST_DONE: stateD = BBS_ST_IDLE;
            default: stateD = BBS_ST_IDLE;
        endcase
    end

    // ==========================================
    // accumulator: instruction result beats a same-cycle software write
    always_comb begin
        accD = accQ;
        if (accWrite) begin
            accD = regWrData;
        end
        if (fmtNow) begin
            accD = bcdSum;
        end
    end

    // ==========================================
    // flags: instruction rewrites only its own flags, and beats a clear
    always_comb begin
        flagsD = bbs_flags_type'(flagsQ & ~flagClear);
        if (calcNow) begin
            case (opQ)
                BBS_OP_WORD_DECREMENT: begin
                    flagsD.zeroResultFlag = decNew == '0;
                end
                BBS_OP_BITRANGE_BCD_ADD: begin
                    flagsD.zeroResultFlag = bcdSum == '0;
                    flagsD.carry16Flag = aluBus.carry16;
                    flagsD.carry32Flag = aluBus.carry32;
                    flagsD.negativeFlag = 1'b0;
                    flagsD.invalidBcdFlag = aluBus.invalidBcd;
                end
                BBS_OP_BITRANGE_BCD_SUB: begin
                    flagsD.zeroResultFlag = bcdSum == '0;
                    flagsD.borrow16Flag = !aluBus.carry16;
                    flagsD.borrow32Flag = !aluBus.carry32;
                    // result left in ten's complement when below zero
                    flagsD.negativeFlag = !aluBus.carry32;
                    flagsD.invalidBcdFlag = aluBus.invalidBcd;
                end
                default: begin
                    flagsD = flagsD;
                end
            endcase
        end
    end

    // ==========================================
    // sequencing registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateQ <= BBS_ST_IDLE;
            rejectQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            rejectQ <= refuse;
        end
    end

    // operands are latched so later port changes cannot disturb the calc cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            opQ <= BBS_OP_NONE;
            srcQ <= 8'h00;
            cntQ <= 6'h00;
        end else if (accept) begin
            opQ <= instOp;
            srcQ <= instSrcAddr;
            cntQ <= instBitCount;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accQ <= `BBS_ACC_RST;
            flagsQ <= bbs_flags_type'(`BBS_FLAG_RST);
        end else begin
            accQ <= accD;
            flagsQ <= flagsD;
        end
    end

    // last result and last formatted operand, for software inspection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resultQ <= 32'h00000000;
            operandQ <= 32'h00000000;
        end else if (fmtNow) begin
            resultQ <= bcdSum;
            operandQ <= fmtOperand;
        end else if (decNow) begin
            resultQ <= {16'h0000, decNew};
        end
    end

    // ==========================================
    // discrete bit and word storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitMemQ <= '{default: 32'h00000000};
        end else if (bitWrite) begin
            bitMemQ[bitIdx] <= regWrData;
        end
    end

    // decrement write-back comes last so it wins on the same word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wordMemQ <= '{default: 16'h0000};
        end else begin
            if (wordWrite) begin
                wordMemQ[wordIdx] <= regWrData[`BBS_WORD_W-1:0];
            end
            if (decNow) begin
                wordMemQ[decIdx] <= decNew;
            end
        end
    end

    // ==========================================
    // read port: data stand one cycle after the strobe, zero otherwise
    assign rdMux = selAcc ? accQ :
                   selFlag ? {25'h0000000, flagsQ} :
                   selStat ? {27'h0000000, opQ, stateQ, instBusy} :
                   selResult ? resultQ :
                   selOperand ? operandQ :
                   selBit ? bitMemQ[bitIdx] :
                   selWord ? {16'h0000, wordMemQ[wordIdx]} :
                   32'h00000000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdDataQ <= 32'h00000000;
        end else begin
            rdDataQ <= regRdEn ? rdMux : 32'h00000000;
        end
    end

    // ==========================================
    // outputs
    assign instBusy = !idle;
    assign instDone = stateQ == BBS_ST_DONE;
    assign instReject = rejectQ;
    assign regRdData = rdDataQ;
    assign accValue = accQ;
    assign zeroResultFlag = flagsQ.zeroResultFlag;
    assign borrow16Flag = flagsQ.borrow16Flag;
    assign borrow32Flag = flagsQ.borrow32Flag;
    assign carry16Flag = flagsQ.carry16Flag;
    assign carry32Flag = flagsQ.carry32Flag;
    assign negativeFlag = flagsQ.negativeFlag;
    assign invalidBcdFlag = flagsQ.invalidBcdFlag;

endmodule

// *** verilog/bbs_bcd_adder.sv ***
// eight-digit packed BCD adder/subtractor
// subtracts by nines complement plus carry in; carry out low means borrow
`timescale 1ns/1ps
`include "bbs_params.svh"
module bbs_bcd_adder (
    // operands and results
    bbs_alu_if.alu alu
);
    logic [`BBS_DIGIT_N:0] carryChain;
    logic [`BBS_DIGIT_N-1:0] badDigit;
    wire [`BBS_DATA_W-1:0] sumWord;

    assign carryChain[0] = alu.subtract;

    // ==========================================
    // one decimal digit per stage
    for (genvar g = 0; g < `BBS_DIGIT_N; g++) begin : g_digit
        logic [3:0] aDig;
        logic [3:0] bDig;
        logic [3:0] bEff;
        logic [4:0] raw;
        logic [4:0] fixed;
        logic adjust;
        assign aDig = alu.augend[4*g +: 4];
        assign bDig = alu.addend[4*g +: 4];
        assign bEff = alu.subtract ? 4'h9 - bDig : bDig;
        assign raw = {1'b0, aDig} + {1'b0, bEff} + {4'h0, carryChain[g]};
        assign adjust = raw > 5'h09;
        assign fixed = raw + 5'h06;
        assign sumWord[4*g +: 4] = adjust ? fixed[3:0] : raw[3:0];
        assign carryChain[g+1] = adjust;
        assign badDigit[g] = (aDig > 4'h9) | (bDig > 4'h9);
    end

    assign alu.result = sumWord;
    assign alu.carry16 = carryChain[4];
    assign alu.carry32 = carryChain[`BBS_DIGIT_N];
    assign alu.invalidBcd = |badDigit;
endmodule

// *** verilog/bbs_bit_gather.sv ***
// forms the formatted operand from a run of discrete bits
// purely combinational; the caller checks the count range
`timescale 1ns/1ps
`include "bbs_params.svh"
module bbs_bit_gather (
    // discrete bit image
    input logic [`BBS_BIT_N-1:0] bitVec,
    // run selection
    input logic [7:0] startBit,
    input logic [5:0] bitCount,
    // packed operand
    output logic [`BBS_DATA_W-1:0] operand
);
    logic [`BBS_BIT_N-1:0] shifted;

    // ==========================================
    // align start bit to bit 0, zero above count
    assign shifted = bitVec >> startBit;

    for (genvar i = 0; i < `BBS_DATA_W; i++) begin : g_bit
        assign operand[i] = shifted[i] & (6'(i) < bitCount);
    end
endmodule
